// [prbs_eye_defs.svh]
// Purpose: Offsets, field positions and reset values of the checker and eye-scan status bank.
// Assumes: Word addresses as seen on the serial control port, 16-bit registers.
// Notes:   Definitions only.
`ifndef PRBS_EYE_DEFS_SVH
`define PRBS_EYE_DEFS_SVH

`define ADDR_PATTERN_CHECK_RESULT   8'h8A
`define ADDR_SCAN_SEGMENT_BYTES     8'h8B
`define ADDR_SHAPE_LEFT_EDGE        8'h8C
`define ADDR_SHAPE_TOP_EDGE         8'h8D
`define ADDR_SHAPE_RIGHT_EDGE       8'h8E
`define ADDR_SHAPE_BOTTOM_EDGE      8'h8F
`define ADDR_PATTERN_ERROR_TALLY    8'h89

`define BIT_NO_TRANSITION           9
`define BIT_CHECK_ABORT             8
`define STATE_MSB                   1
`define STATE_LSB                   0
`define EDGE_VOLT_MSB               15
`define EDGE_VOLT_LSB               8
`define EDGE_PHASE_MSB              6
`define EDGE_PHASE_LSB              0

`define STATE_IDLE                  2'h0
`define STATE_BUSY                  2'h1
`define STATE_DONE                  2'h2
`define STATE_ABORTED               2'h3

`define RESET_WORD                  16'h0000
`define RESET_BYTE                  8'h00
`define RESET_PHASE                 7'h00

`endif

// [prbs_eye_pkg.sv]
// Purpose: Types shared by the status bank and its edge holder.
// Assumes: Constants live in prbs_eye_defs.svh.
// Notes:   Edge results travel as one packed struct.
package prbs_eye_pkg;

	typedef enum logic [1:0] {
		ck_idle,
		ck_busy,
		ck_done,
		ck_aborted
	} checker_fsm_t;

	typedef struct packed {
		logic [7:0] voltage;
		logic [6:0] phase;
	} edge_result_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
	} host_access_t;

endpackage : prbs_eye_pkg

// [edge_result_holder.sv]
// Purpose: Holds one shape-scan edge result and presents it as a 16-bit status word.
// Assumes: Load pulse comes from eye-monitor logic on mclk.
// Notes:   Used once for each of the four edges.
`timescale 1ns/1ps
`default_nettype none
`include "prbs_eye_defs.svh"

module edge_result_holder
(
	input  wire logic                        mclk,
	input  wire logic                        sys_rst,
	input  wire logic                        load,
	input  wire prbs_eye_pkg::edge_result_t  new_result,
	output var  logic [15:0]                 status_word
);
	import prbs_eye_pkg::*;

	edge_result_t held;
	edge_result_t next_held;

	always_comb
	begin
		next_held = held;
		if (load)
		begin
			next_held = new_result;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			held <= '{voltage: `RESET_BYTE, phase: `RESET_PHASE};
		end
		else
		begin
			held <= next_held;
		end
	end

	// Phase is kept to seven bits so values above 127 can never be shown.
	always_comb
	begin
		status_word = `RESET_WORD;
		status_word[`EDGE_VOLT_MSB:`EDGE_VOLT_LSB] = held.voltage;
		status_word[`EDGE_PHASE_MSB:`EDGE_PHASE_LSB] = held.phase;
	end

endmodule : edge_result_holder
`default_nettype wire

// [prbs_eye_result_status.sv]
// Purpose: Read-only status bank for the pattern checker and the eye-monitor shape scan.
// Assumes: Host accesses arrive as single-cycle strobes on mclk from the serial control port.
// Notes:   Checker events come from logic on the same clock and are not synchronised.
//
// Behaviour
// - Bit 9 set when preceding check saw no transitions, else 0.
// - No-transition flag changes only at completion; holds until next request.
// - No-transition flag is meaningless whenever the abort flag reads 1.
// - Bit 8 set when check abandoned by lock loss or sleep; holds.
// - Bits 1:0 report idle, busy, done or aborted checker state.
// - State and check request form a four-phase handshake with the host.
// - Report aborted if lock loss or sleep occurs or already existed.
// - All-zero input leaves error count zero; flag distinguishes absent data.
// - Sixteen-bit field reports bytes in last partial scan segment.
// - Edge results at four consecutive registers: left, top, right, bottom.
// - Edge voltage offset in bits 15:8, 127 meaning zero volts.
// - Edge phase in bits 6:0, legal values 0 to 127.
// - Error count cleared at measurement start, updated only at completion.
`timescale 1ns/1ps
`default_nettype none
`include "prbs_eye_defs.svh"

module prbs_eye_result_status
(
	input  wire logic                        mclk,
	input  wire logic                        sys_rst,
	input  wire prbs_eye_pkg::host_access_t  host_access,
	input  wire logic [15:0]                 host_wdata,
	output var  logic [15:0]                 host_rdata,
	input  wire logic                        check_request,
	input  wire logic                        check_timed,
	input  wire logic                        lock_lost,
	input  wire logic                        sleep_active,
	input  wire logic                        check_finish,
	input  wire logic                        data_transition_seen,
	input  wire logic                        pattern_error_hit,
	input  wire logic                        segment_valid,
	input  wire logic [15:0]                 segment_byte_count,
	input  wire logic [3:0]                  edge_load,
	input  wire prbs_eye_pkg::edge_result_t  left_edge,
	input  wire prbs_eye_pkg::edge_result_t  top_edge,
	input  wire prbs_eye_pkg::edge_result_t  right_edge,
	input  wire prbs_eye_pkg::edge_result_t  bottom_edge,
	output var  logic [1:0]                  checker_state,
	output var  logic                        no_transition_flag,
	output var  logic                        check_abort_flag
);
	import prbs_eye_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	checker_fsm_t fsm;
	checker_fsm_t next_fsm;
	logic         no_transition;
	logic         next_no_transition;
	logic         abort_flag;
	logic         next_abort_flag;
	logic         seen_edge;
	logic         next_seen_edge;
	logic [15:0]  pattern_error_tally;
	logic [15:0]  next_pattern_error_tally;
	logic [15:0]  running_tally;
	logic [15:0]  next_running_tally;
	logic         fault;

	assign fault = lock_lost | sleep_active;

	// The running count is kept apart so the visible tally never moves mid-measurement.
	always_comb
	begin
		next_fsm                 = fsm;
		next_no_transition       = no_transition;
		next_abort_flag          = abort_flag;
		next_seen_edge           = seen_edge;
		next_pattern_error_tally = pattern_error_tally;
		next_running_tally       = running_tally;
		case (fsm)
			ck_idle:
			begin
				if (check_request)
				begin
					next_abort_flag    = 1'b0;
					next_no_transition = 1'b0;
					next_seen_edge     = 1'b0;
					next_running_tally = `RESET_WORD;
					next_pattern_error_tally = `RESET_WORD;
					if (fault)
					begin
						next_fsm        = ck_aborted;
						next_abort_flag = 1'b1;
					end
					else
					begin
						next_fsm = ck_busy;
					end
				end
			end
			ck_busy:
			begin
				if (data_transition_seen)
				begin
					next_seen_edge = 1'b1;
				end
				if (pattern_error_hit && running_tally != 16'hFFFF)
				begin
					next_running_tally = running_tally + 16'h0001;
				end
				if (fault)
				begin
					// Flag is left as it was; its value means nothing after an abort.
					next_fsm        = ck_aborted;
					next_abort_flag = 1'b1;
				end
				else if (!check_request)
				begin
					// Host dropped the request of a timed or continuous check: finish it now.
					next_fsm = ck_done;
					next_no_transition = !(seen_edge | data_transition_seen);
					next_pattern_error_tally = running_tally;
				end
				else if (check_timed && check_finish)
				begin
					next_fsm = ck_done;
					next_no_transition = !(seen_edge | data_transition_seen);
					next_pattern_error_tally = running_tally;
				end
			end
			ck_done,
			ck_aborted:
			begin
				if (!check_request)
				begin
					next_fsm = ck_idle;
				end
			end
			default:
			begin
				next_fsm = ck_idle;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			fsm                 <= ck_idle;
			no_transition       <= 1'b0;
			abort_flag          <= 1'b0;
			seen_edge           <= 1'b0;
			pattern_error_tally <= `RESET_WORD;
			running_tally       <= `RESET_WORD;
		end
		else
		begin
			fsm                 <= next_fsm;
			no_transition       <= next_no_transition;
			abort_flag          <= next_abort_flag;
			seen_edge           <= next_seen_edge;
			pattern_error_tally <= next_pattern_error_tally;
			running_tally       <= next_running_tally;
		end
	end

	always_comb
	begin
		case (fsm)
			ck_busy:    checker_state = `STATE_BUSY;
			ck_done:    checker_state = `STATE_DONE;
			ck_aborted: checker_state = `STATE_ABORTED;
			default:    checker_state = `STATE_IDLE;
		endcase
	end

	assign no_transition_flag = no_transition;
	assign check_abort_flag   = abort_flag;

	////////////////////////////////////////////////////////////////////////////
	logic [15:0] segment_bytes;
	logic [15:0] next_segment_bytes;

	always_comb
	begin
		next_segment_bytes = segment_bytes;
		if (segment_valid)
		begin
			next_segment_bytes = segment_byte_count;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			segment_bytes <= `RESET_WORD;
		end
		else
		begin
			segment_bytes <= next_segment_bytes;
		end
	end

	logic [15:0] edge_word [4];

	edge_result_holder u_left
	(
		.mclk        (mclk),
		.sys_rst     (sys_rst),
		.load        (edge_load[0]),
		.new_result  (left_edge),
		.status_word (edge_word[0])
	);

	edge_result_holder u_top
	(
		.mclk        (mclk),
		.sys_rst     (sys_rst),
		.load        (edge_load[1]),
		.new_result  (top_edge),
		.status_word (edge_word[1])
	);

	edge_result_holder u_right
	(
		.mclk        (mclk),
		.sys_rst     (sys_rst),
		.load        (edge_load[2]),
		.new_result  (right_edge),
		.status_word (edge_word[2])
	);

	edge_result_holder u_bottom
	(
		.mclk        (mclk),
		.sys_rst     (sys_rst),
		.load        (edge_load[3]),
		.new_result  (bottom_edge),
		.status_word (edge_word[3])
	);

	////////////////////////////////////////////////////////////////////////////
	// Write strobes and data are deliberately ignored: every word here is read-only.
	logic [15:0] read_word;
	logic [15:0] next_rdata;

	always_comb
	begin
		read_word = `RESET_WORD;
		if (host_access.addr == `ADDR_PATTERN_CHECK_RESULT)
		begin
			read_word[`BIT_NO_TRANSITION]          = no_transition;
			read_word[`BIT_CHECK_ABORT]            = abort_flag;
			read_word[`STATE_MSB:`STATE_LSB]       = checker_state;
		end
		else if (host_access.addr == `ADDR_PATTERN_ERROR_TALLY)
		begin
			read_word = pattern_error_tally;
		end
		else if (host_access.addr == `ADDR_SCAN_SEGMENT_BYTES)
		begin
			read_word = segment_bytes;
		end
		else if (host_access.addr == `ADDR_SHAPE_LEFT_EDGE)
		begin
			read_word = edge_word[0];
		end
		else if (host_access.addr == `ADDR_SHAPE_TOP_EDGE)
		begin
			read_word = edge_word[1];
		end
		else if (host_access.addr == `ADDR_SHAPE_RIGHT_EDGE)
		begin
			read_word = edge_word[2];
		end
		else if (host_access.addr == `ADDR_SHAPE_BOTTOM_EDGE)
		begin
			read_word = edge_word[3];
		end
	end

	always_comb
	begin
		next_rdata = host_rdata;
		if (host_access.rd)
		begin
			next_rdata = read_word;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			host_rdata <= `RESET_WORD;
		end
		else
		begin
			host_rdata <= next_rdata;
		end
	end

endmodule : prbs_eye_result_status
`default_nettype wire

// [prbs_eye_checker.sv]
// Purpose: Concurrent checks on the ports of the checker status bank.
// Assumes: One mclk domain, sys_rst synchronous and active high.
// Notes:   Bound to every instance of the status bank.
`timescale 1ns/1ps
`default_nettype none
module prbs_eye_checker
(
	input wire logic                       mclk,
	input wire logic                       sys_rst,
	input wire prbs_eye_pkg::host_access_t host_access,
	input wire logic [15:0]                host_rdata,
	input wire logic                       check_request,
	input wire logic                       check_timed,
	input wire logic                       lock_lost,
	input wire logic                       sleep_active,
	input wire logic                       check_finish,
	input wire logic                       data_transition_seen,
	input wire logic [1:0]                 checker_state,
	input wire logic                       no_transition_flag,
	input wire logic                       check_abort_flag
);
	import prbs_eye_pkg::*;
	////////////////////////////////////////////////////////////////////////////////
	// Transitions are tracked only while busy, so a stale one never leaks into a check.
	logic fault;
	logic seen;
	logic next_seen;
	logic seen_now;
	assign fault = lock_lost | sleep_active;
	assign seen_now = seen | data_transition_seen;
	always_comb next_seen = (checker_state == 2'h1) ? seen_now : 1'b0;
	always_ff @(posedge mclk) seen <= sys_rst ? 1'b0 : next_seen;
	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_take_busy: assert property (checker_state == 2'h0 && check_request && !fault
		|=> checker_state == 2'h1 && !no_transition_flag) else $error("start not taken");
	a_busy_abort: assert property (checker_state == 2'h1 && fault
		|=> checker_state == 2'h3 && check_abort_flag) else $error("fault not reported");
	a_timed_done: assert property (checker_state == 2'h1 && !fault && check_timed && check_finish
		|=> checker_state == 2'h2 && !check_abort_flag) else $error("timed end missed");
	a_no_transition: assert property (checker_state == 2'h1 && !fault && check_timed
		&& check_finish |=> no_transition_flag == !$past(seen_now)) else $error("flag wrong");
	a_busy_steady: assert property (checker_state == 2'h1 ##1 checker_state == 2'h1
		|-> $stable(no_transition_flag) && $stable(check_abort_flag)) else $error("flag moved");
	a_final_hold: assert property (checker_state[1] && check_request |=> $stable(checker_state)
		&& $stable(no_transition_flag) && $stable(check_abort_flag)) else $error("result moved");
	a_release_idle: assert property (checker_state[1] && !check_request
		|=> checker_state == 2'h0) else $error("no return to idle");
	a_status_word: assert property (host_access.rd && host_access.addr == 8'h8A
		|=> host_rdata == {6'h00, $past(no_transition_flag), $past(check_abort_flag), 6'h00,
		$past(checker_state)}) else $error("status word wrong");
	a_write_ignored: assert property (host_access.wr && !host_access.rd
		|=> $stable(host_rdata)) else $error("write changed read data");
	a_request_fault: assert property (checker_state == 2'h0 && check_request && fault
		|=> checker_state == 2'h3 && check_abort_flag) else $error("early fault not reported");
	a_idle_hold: assert property (checker_state == 2'h0 && !check_request
		|=> $stable(no_transition_flag) && $stable(check_abort_flag)) else $error("idle result moved");
	c_done: cover property (checker_state == 2'h2);
	c_abort: cover property (checker_state == 2'h3);
	c_flag_read: cover property (host_access.rd && no_transition_flag);
endmodule : prbs_eye_checker
bind prbs_eye_result_status prbs_eye_checker checker_i (.mclk, .sys_rst, .host_access,
	.host_rdata, .check_request, .check_timed, .lock_lost, .sleep_active, .check_finish,
	.data_transition_seen, .checker_state, .no_transition_flag, .check_abort_flag);
`default_nettype wire

// [host_model.sv]
// Purpose: Host side of the serial control port and of the check request.
// Assumes: Requests change 1 ns after the rising edge of mclk.
// Notes:   Read data is registered, so it is taken one edge after the strobe.
`timescale 1ns/1ps
`default_nettype none
module host_model
(
	input  wire logic                       mclk,
	input  wire logic [15:0]                host_rdata,
	output var  prbs_eye_pkg::host_access_t host_access,
	output var  logic [15:0]                host_wdata,
	output var  logic                       check_request
);
	import prbs_eye_pkg::*;
	initial
	begin
		host_access = '0;
		host_wdata = 16'h0000;
		check_request = 1'b0;
	end
	task rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge mclk);
		#1;
		host_access = '{wr: 1'b0, rd: 1'b1, addr: a};
		@(posedge mclk);
		#1;
		host_access.rd = 1'b0;
		d = host_rdata;
	endtask : rd
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		#1;
		host_access = '{wr: 1'b1, rd: 1'b0, addr: a};
		host_wdata = d;
		@(posedge mclk);
		#1;
		host_access.wr = 1'b0;
	endtask : wr
	// The caller drops a continuous check while busy, a timed one after done or aborted, and waits for idle before raising.
	task req(input logic v);
		@(posedge mclk);
		#1;
		check_request = v;
	endtask : req
endmodule : host_model
`default_nettype wire

// [prbs_eye_result_status_tb.sv]
// Purpose: Self-checking bench for the checker status bank.
// Assumes: Inputs change 1 ns after the rising edge of mclk.
// Notes:   Expected words are built from the field layout, never read back.
`timescale 1ns/1ps
`default_nettype none
module prbs_eye_result_status_tb;
	import prbs_eye_pkg::*;
	logic         mclk = 1'b0, sys_rst = 1'b1, check_timed = 1'b0, lock_lost = 1'b0;
	logic         sleep_active = 1'b0, check_finish = 1'b0, data_transition_seen = 1'b0;
	logic         pattern_error_hit = 1'b0, segment_valid = 1'b0;
	logic [15:0]  segment_byte_count = 16'h0000;
	logic [3:0]   edge_load = 4'h0;
	edge_result_t left_edge = '0, top_edge = '0, right_edge = '0, bottom_edge = '0;
	host_access_t host_access;
	logic [15:0]  host_wdata, host_rdata, d;
	logic         check_request, no_transition_flag, check_abort_flag;
	logic [1:0]   checker_state;
	int           failures = 0, checks_done = 0, cycles = 0;
	always #5 mclk = ~mclk;
	prbs_eye_result_status dut (.mclk, .sys_rst, .host_access, .host_wdata, .host_rdata,
		.check_request, .check_timed, .lock_lost, .sleep_active, .check_finish,
		.data_transition_seen, .pattern_error_hit, .segment_valid, .segment_byte_count,
		.edge_load, .left_edge, .top_edge, .right_edge, .bottom_edge, .checker_state,
		.no_transition_flag, .check_abort_flag);
	host_model host (.mclk, .host_rdata, .host_access, .host_wdata, .check_request);
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			failures++;
			finish_test();
		end
	end
	task finish_test();
		$display("Checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	task step();
		@(posedge mclk);
		#1;
	endtask : step
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// The mask hides a bit whose value is left open, as after an abort.
	task rchk(input logic [7:0] a, input logic [15:0] e, input logic [15:0] mask);
		host.rd(a, d);
		chk($sformatf("reg_%h", a), e, d & mask);
	endtask : rchk
	task st(input logic [1:0] e);
		chk("checker_state", {14'h0000, e}, {14'h0000, checker_state});
	endtask : st
	////////////////////////////////////////////////////////////////////////////////
	task t_reset_writes();
		rchk(8'h8A, 16'h0000, 16'hFFFF);
		host.wr(8'h8B, 16'h1234);
		host.wr(8'h8A, 16'hFFFF);
		rchk(8'h8B, 16'h0000, 16'hFFFF);
		rchk(8'h8A, 16'h0000, 16'hFFFF);
		rchk(8'h90, 16'h0000, 16'hFFFF);
		$display("t_reset_writes done");
	endtask : t_reset_writes
	task t_continuous();
		host.req(1'b1);
		step();
		st(2'h1);
		data_transition_seen = 1'b1;
		pattern_error_hit = 1'b1;
		repeat (3) step();
		data_transition_seen = 1'b0;
		pattern_error_hit = 1'b0;
		rchk(8'h89, 16'h0000, 16'hFFFF);
		host.req(1'b0);
		step();
		st(2'h2);
		step();
		st(2'h0);
		rchk(8'h89, 16'h0003, 16'hFFFF);
		rchk(8'h8A, 16'h0000, 16'hFFFF);
		$display("t_continuous done");
	endtask : t_continuous
	task t_timed_nodata();
		check_timed = 1'b1;
		host.req(1'b1);
		step();
		rchk(8'h89, 16'h0000, 16'hFFFF);
		check_finish = 1'b1;
		step();
		check_finish = 1'b0;
		st(2'h2);
		rchk(8'h8A, 16'h0202, 16'hFFFF);
		rchk(8'h89, 16'h0000, 16'hFFFF);
		host.req(1'b0);
		step();
		rchk(8'h8A, 16'h0200, 16'hFFFF);
		$display("t_timed_nodata done");
	endtask : t_timed_nodata
	task t_abort();
		// A continuous check must abort just as a timed one does.
		check_timed = 1'b0;
		host.req(1'b1);
		step();
		lock_lost = 1'b1;
		step();
		lock_lost = 1'b0;
		st(2'h3);
		rchk(8'h8A, 16'h0103, 16'hFDFF);
		host.req(1'b0);
		step();
		rchk(8'h8A, 16'h0100, 16'hFDFF);
		sleep_active = 1'b1;
		host.req(1'b1);
		step();
		st(2'h3);
		sleep_active = 1'b0;
		host.req(1'b0);
		step();
		st(2'h0);
		$display("t_abort done");
	endtask : t_abort
	task t_scan_results();
		edge_result_t e [4];
		edge_result_t f [4];
		e = '{'{8'h00, 7'h7F}, '{8'h7F, 7'h00}, '{8'hFF, 7'h40}, '{8'h80, 7'h01}};
		f = '{'{8'h01, 7'h02}, '{8'hFE, 7'h7E}, '{8'h55, 7'h2A}, '{8'hAA, 7'h55}};
		left_edge = e[0];
		top_edge = e[1];
		right_edge = e[2];
		bottom_edge = e[3];
		edge_load = 4'hF;
		segment_byte_count = 16'hFFFF;
		segment_valid = 1'b1;
		step();
		edge_load = 4'h0;
		segment_valid = 1'b0;
		host.wr(8'h8C, 16'h0000);
		rchk(8'h8B, 16'hFFFF, 16'hFFFF);
		for (int i = 0; i < 4; i++)
			rchk(8'h8C + 8'(i), {e[i].voltage, 1'b0, e[i].phase}, 16'hFFFF);
		// Only left and bottom load now, so top and right must keep the first round.
		left_edge = f[0];
		top_edge = f[1];
		right_edge = f[2];
		bottom_edge = f[3];
		edge_load = 4'h9;
		segment_byte_count = 16'h0155;
		segment_valid = 1'b1;
		step();
		edge_load = 4'h0;
		segment_valid = 1'b0;
		segment_byte_count = 16'hAAAA;
		e[0] = f[0];
		e[3] = f[3];
		rchk(8'h8B, 16'h0155, 16'hFFFF);
		for (int i = 0; i < 4; i++)
			rchk(8'h8C + 8'(i), {e[i].voltage, 1'b0, e[i].phase}, 16'hFFFF);
		$display("t_scan_results done");
	endtask : t_scan_results
	task t_mid_reset();
		host.req(1'b1);
		step();
		st(2'h1);
		sys_rst = 1'b1;
		host.req(1'b0);
		step();
		sys_rst = 1'b0;
		st(2'h0);
		step();
		st(2'h0);
		rchk(8'h8A, 16'h0000, 16'hFFFF);
		rchk(8'h8C, 16'h0000, 16'hFFFF);
		rchk(8'h8B, 16'h0000, 16'hFFFF);
		$display("t_mid_reset done");
	endtask : t_mid_reset
	initial
	begin
		repeat (2) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		t_reset_writes();
		t_continuous();
		t_timed_nodata();
		t_abort();
		t_scan_results();
		t_mid_reset();
		finish_test();
	end
endmodule : prbs_eye_result_status_tb
`default_nettype wire
